// file: design/watchdog_reset_cause_flag_pkg.sv
// Package of constants and types for the watchdog with reset-cause flags
`default_nettype none
package watchdog_reset_cause_flag_pkg;

  // ------------------------------------------------------------------
  // Register byte addresses
  // ------------------------------------------------------------------
  localparam logic [7:0] WATCHDOG_RESET_CAUSE_FLAG_CTRL_ADDR  = 8'h60;
  localparam logic [7:0] WATCHDOG_RESET_CAUSE_FLAG_CAUSE_ADDR = 8'h54;

  // ------------------------------------------------------------------
  // Control register fields
  // ------------------------------------------------------------------
  localparam int CTRL_FLAG_BIT = 7;
  localparam int CTRL_IE_BIT   = 6;
  localparam int CTRL_P3_BIT   = 5;
  localparam int CTRL_CE_BIT   = 4;
  localparam int CTRL_RE_BIT   = 3;
  localparam int CTRL_P2_BIT   = 2;
  localparam int CTRL_P0_BIT   = 0;

  // ------------------------------------------------------------------
  // Reset-cause register fields
  // ------------------------------------------------------------------
  localparam int CAUSE_POR_BIT = 0;
  localparam int CAUSE_EXT_BIT = 1;
  localparam int CAUSE_BOR_BIT = 2;
  localparam int CAUSE_WDR_BIT = 3;
  localparam int CAUSE_WIDTH   = 4;

  // ------------------------------------------------------------------
  // Reset values, limits and timing
  // ------------------------------------------------------------------
  localparam logic       RE_RESET        = 1'b0;
  localparam logic [3:0] PERIOD_RESET    = 4'h0;
  localparam logic [3:0] PERIOD_MAX_CODE = 4'h9;
  localparam int         BASE_TICKS_DEF  = 2048;
  localparam int         TICK_CNT_W      = 21;
  localparam int         CE_CYCLES       = 4;
  localparam logic [2:0] CE_LOAD         = 3'(CE_CYCLES - 1);

  // Operating mode, {reset enable, interrupt enable}
  typedef enum logic [1:0] {
    WATCHDOG_RESET_CAUSE_FLAG_STOPPED = 2'b00,
    WATCHDOG_RESET_CAUSE_FLAG_INT     = 2'b01,
    WATCHDOG_RESET_CAUSE_FLAG_RST     = 2'b10,
    WATCHDOG_RESET_CAUSE_FLAG_INT_RST = 2'b11
  } watchdog_reset_cause_flag_mode_t;

endpackage
`default_nettype wire

// file: design/watchdog_reset_cause_flag_watchdog.sv
// Watchdog timer with reset-cause status register on an Avalon-MM slave
//
// The Avalon-MM register port was left to the implementer.
`default_nettype none
// Overview of operation
// - Cause register bits 7:4 read zero
// - Watchdog reset sets bit 3; zero-write clears
// - Brown-out sets bit 2; zero-write clears
// - External reset sets bit 1; zero-write clears
// - Power-on sets bit 0; only zero-write clears
// - Time-out in interrupt mode sets flag 7
// - Vector execution or writing one clears flag
// - Interrupt needs global enable, enable, flag
// - Vector in combined mode clears enable, flag
// - Unserviced flag at next time-out resets in combined mode
// - Enables select stopped, interrupt, reset, combined
// - Programmed fuse forces system reset mode
// - Clearing reset enable or period needs change-enable
// - Change-enable self-clears four cycles later
// - Cause bit 3 forces reset enable on
// - Period codes 0-9 give 2048..1048576 ticks
// - Period bit 3 at 5, bits 2:0 at 2:0
// - Set change and reset enable, then write
// - Programmed fuse locks enables at one, zero
// - Counter advances on slow oscillator ticks
// - Watchdog reset pulse lasts one clock
module watchdog_reset_cause_flag_watchdog
  import watchdog_reset_cause_flag_pkg::*;
#(
  parameter int BASE_TICKS = BASE_TICKS_DEF
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        sys_rst,
  // Avalon-MM slave
  input  wire logic [7:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  // Pins and processor side
  input  wire logic        slow_osc,
  input  wire logic        always_on_fuse,
  input  wire logic        global_int_enable,
  input  wire logic        vector_ack,
  input  wire logic        restart_req,
  input  wire logic        brownout_event,
  input  wire logic        external_event,
  // Outputs
  output logic             wdog_irq,
  output logic             wdog_reset_pulse
);

  // ------------------------------------------------------------------
  // State
  // ------------------------------------------------------------------
  logic                   osc_s1;
  logic                   osc_s2;
  logic                   osc_s3;
  logic                   fuse_s1;
  logic                   fuse_s2;
  logic                   timeout_flag;
  logic                   int_enable;
  logic                   reset_enable;
  logic                   change_enable;
  logic [2:0]             ce_count;
  logic [3:0]             period_select;
  logic                   restart_pend;
  logic [TICK_CNT_W-1:0]  tick_count;
  logic [CAUSE_WIDTH-1:0] cause;

  // ------------------------------------------------------------------
  // Bus decode
  // ------------------------------------------------------------------
  wire logic       hit_ctrl  = (avs_address == WATCHDOG_RESET_CAUSE_FLAG_CTRL_ADDR);
  wire logic       hit_cause = (avs_address == WATCHDOG_RESET_CAUSE_FLAG_CAUSE_ADDR);
  wire logic       wr_go     = avs_write & ~avs_waitrequest & avs_byteenable[0];
  wire logic       wr_ctrl   = wr_go & hit_ctrl;
  wire logic       wr_cause  = wr_go & hit_cause;
  wire logic [7:0] wdata     = avs_writedata[7:0];

  // ------------------------------------------------------------------
  // Mode selection
  // ------------------------------------------------------------------
  wire logic       fuse_prog = ~fuse_s2;
  wire logic       re_eff    = reset_enable | cause[CAUSE_WDR_BIT] | fuse_prog;
  wire logic       ie_eff    = int_enable & ~fuse_prog;
  wire watchdog_reset_cause_flag_mode_t mode      = watchdog_reset_cause_flag_mode_t'({re_eff, ie_eff});
  wire logic       running   = (mode != WATCHDOG_RESET_CAUSE_FLAG_STOPPED);
  wire logic       combined  = (mode == WATCHDOG_RESET_CAUSE_FLAG_INT_RST);

  // ------------------------------------------------------------------
  // Tick and time-out
  // ------------------------------------------------------------------
  wire logic                  tick    = osc_s2 & ~osc_s3;
  wire logic [TICK_CNT_W-1:0] tgt_m1  = (TICK_CNT_W'(BASE_TICKS) << period_select)
                                        - TICK_CNT_W'(1);
  wire logic                  timeout = tick & running & ~restart_pend
                                        & (tick_count == tgt_m1);
  wire logic                  set_flag  = timeout & ie_eff & ~(re_eff & timeout_flag);
  wire logic                  reset_now = timeout & re_eff & (~ie_eff | timeout_flag);

  // ------------------------------------------------------------------
  // Protected writes
  // ------------------------------------------------------------------
  wire logic ce_load    = wr_ctrl & wdata[CTRL_CE_BIT] & wdata[CTRL_RE_BIT];
  wire logic code_ok    = ({wdata[CTRL_P3_BIT], wdata[CTRL_P2_BIT:CTRL_P0_BIT]}
                           <= PERIOD_MAX_CODE);
  wire logic per_write  = wr_ctrl & change_enable & code_ok;
  wire logic ack_clr_ie = vector_ack & combined;

  // Readback images
  wire logic [7:0] ctrl_image  = {timeout_flag, ie_eff, period_select[3], change_enable,
                                  re_eff, period_select[2:0]};
  wire logic [7:0] cause_image = {4'h0, cause};
  wire logic [7:0] read_mux    = hit_ctrl  ? ctrl_image :
                                 hit_cause ? cause_image : 8'h00;

  // ------------------------------------------------------------------
  // Input synchronisers; the first stage feeds only the second
  // ------------------------------------------------------------------
  always_ff @(posedge clk) begin
    osc_s1  <= slow_osc;
    osc_s2  <= osc_s1;
    osc_s3  <= osc_s2;
    fuse_s1 <= always_on_fuse;
    fuse_s2 <= fuse_s1;
  end

  // ------------------------------------------------------------------
  // Avalon handshake: one wait cycle, answer registered
  // ------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h0000_0000;
    end else begin
      avs_waitrequest <= ~((avs_read | avs_write) & avs_waitrequest);
      if (avs_read & avs_waitrequest) begin
        avs_readdata <= {24'h00_0000, read_mux};
      end
    end
  end

  // ------------------------------------------------------------------
  // Change-enable window, timed on the core clock
  // ------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      change_enable <= 1'b0;
      ce_count      <= 3'h0;
    end else if (ce_load) begin
      change_enable <= 1'b1;
      ce_count      <= CE_LOAD;
    end else if (wr_ctrl | (change_enable & (ce_count == 3'h0))) begin
      change_enable <= 1'b0;
    end else if (change_enable) begin
      ce_count <= ce_count - 3'h1;
    end
  end

  // ------------------------------------------------------------------
  // Reset enable and period; clearing needs the open window
  // ------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      reset_enable  <= RE_RESET;
      period_select <= PERIOD_RESET;
    end else begin
      // Watchdog cause flag keeps reset enable set until software clears it
      if ((wr_ctrl & wdata[CTRL_RE_BIT]) | cause[CAUSE_WDR_BIT]) begin
        reset_enable <= 1'b1;
      end else if (wr_ctrl & change_enable) begin
        reset_enable <= 1'b0;
      end
      // Reserved codes are refused so the period stays defined
      if (per_write) begin
        period_select <= {wdata[CTRL_P3_BIT], wdata[CTRL_P2_BIT:CTRL_P0_BIT]};
      end
    end
  end

  // ------------------------------------------------------------------
  // Interrupt enable and flag; hardware set beats every clear
  // ------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      int_enable   <= 1'b0;
      timeout_flag <= 1'b0;
    end else begin
      if (ack_clr_ie | reset_now) begin
        int_enable <= 1'b0;
      end else if (wr_ctrl) begin
        int_enable <= wdata[CTRL_IE_BIT];
      end
      if (set_flag) begin
        timeout_flag <= 1'b1;
      end else if (vector_ack | reset_now | (wr_ctrl & wdata[CTRL_FLAG_BIT])) begin
        timeout_flag <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------------
  // Tick counter; restart waits for the next oscillator tick
  // ------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      restart_pend <= 1'b0;
      tick_count   <= '0;
    end else begin
      if (restart_req) begin
        restart_pend <= 1'b1;
      end else if (tick) begin
        restart_pend <= 1'b0;
      end
      if (tick) begin
        if (~running | restart_pend | timeout) begin
          tick_count <= '0;
        end else begin
          tick_count <= tick_count + TICK_CNT_W'(1);
        end
      end
    end
  end

  // ------------------------------------------------------------------
  // Outputs straight from flip-flops
  // ------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wdog_irq         <= 1'b0;
      wdog_reset_pulse <= 1'b0;
    end else begin
      wdog_irq         <= timeout_flag & ie_eff & global_int_enable;
      wdog_reset_pulse <= reset_now;
    end
  end

  // ------------------------------------------------------------------
  // Reset-cause flags; bus reset stands for power-on
  // ------------------------------------------------------------------
  wire logic [CAUSE_WIDTH-1:0] cause_set = {reset_now, brownout_event, external_event, 1'b0};

  genvar gi;
  generate
    for (gi = 1; gi < CAUSE_WIDTH; gi++) begin : g_cause
      // Set wins over a zero-write in the same cycle
      always_ff @(posedge clk) begin
        if (sys_rst) begin
          cause[gi] <= 1'b0;
        end else if (cause_set[gi]) begin
          cause[gi] <= 1'b1;
        end else if (wr_cause & ~wdata[gi]) begin
          cause[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  // Power-on flag survives everything but a zero-write
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cause[CAUSE_POR_BIT] <= 1'b1;
    end else if (wr_cause & ~wdata[CAUSE_POR_BIT]) begin
      cause[CAUSE_POR_BIT] <= 1'b0;
    end
  end

  // ------------------------------------------------------------------
  // Assertions and cover points
  // ------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  cause_upper_zero_a: assert property (
    avs_read & hit_cause & avs_waitrequest |=> avs_readdata[31:4] == 28'h0)
    else $error("cause upper bits not zero");

  wdr_cause_set_a: assert property (
    wdog_reset_pulse |-> cause[CAUSE_WDR_BIT])
    else $error("watchdog cause not set after reset pulse");

  bor_cause_set_a: assert property (
    brownout_event |=> cause[CAUSE_BOR_BIT])
    else $error("brown-out cause not set");

  int_flag_set_a: assert property (
    timeout & (mode == WATCHDOG_RESET_CAUSE_FLAG_INT) |=> timeout_flag ##1 (wdog_irq == global_int_enable
    || !$past(global_int_enable) || !timeout_flag || $past(vector_ack)))
    else $error("time-out flag not set in interrupt mode");

  ack_clears_a: assert property (
    vector_ack & combined & ~set_flag |=> ~timeout_flag & ~int_enable)
    else $error("vector did not clear flag and enable");

  irq_gate_a: assert property (
    wdog_irq |-> $past(global_int_enable) & $past(timeout_flag))
    else $error("interrupt without enable or flag");

  re_forced_a: assert property (
    cause[CAUSE_WDR_BIT] | fuse_prog |-> ctrl_image[CTRL_RE_BIT])
    else $error("reset enable not forced");

  fuse_lock_a: assert property (
    fuse_prog |-> ~ctrl_image[CTRL_IE_BIT] & (mode == WATCHDOG_RESET_CAUSE_FLAG_RST))
    else $error("fuse did not lock enables");

  ce_window_a: assert property (
    ce_load ##1 (~wr_ctrl & ~ce_load) [*4] |=> ~change_enable)
    else $error("change-enable outlived its window");

  reset_one_cycle_a: assert property (
    wdog_reset_pulse |=> ~wdog_reset_pulse)
    else $error("reset pulse longer than one cycle");

  second_timeout_a: assert property (
    timeout & combined & timeout_flag |=> wdog_reset_pulse)
    else $error("unserviced time-out did not reset");

  re_sticky_a: assert property (
    cause[CAUSE_WDR_BIT] |=> reset_enable)
    else $error("reset enable cleared while watchdog cause set");

  fuse_reset_a: assert property (
    timeout & fuse_prog |=> wdog_reset_pulse)
    else $error("programmed fuse time-out did not reset");

  cov_int_c:   cover property (timeout & (mode == WATCHDOG_RESET_CAUSE_FLAG_INT));
  cov_comb_c:  cover property (set_flag & combined ##[1:1000] wdog_reset_pulse);
  cov_prot_c:  cover property (ce_load ##[1:4] per_write);
  cov_clear_c: cover property (wr_cause & ~wdata[CAUSE_POR_BIT]);

endmodule
`default_nettype wire

// file: test/test_watchdog_with_reset_flags.sv
// Self-checking bench for the watchdog with reset-cause status register
`default_nettype none
// ------------------------------------------------------------
// Compare macro: counts every check, reports each mismatch
// ------------------------------------------------------------
`define CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin failures++; \
  $display("[FAIL] %0t ns: got %h expected %h", $time, (got), (exp)); end end
module test_watchdog_with_reset_flags;
  timeunit 1ns;
  timeprecision 1ps;
  import watchdog_reset_cause_flag_pkg::*;
  // Row of the table: a write, or a read with its expected byte
  typedef struct {logic wr; logic [7:0] a; logic [7:0] d; int gap;} watchdog_reset_cause_flag_row_t;
  localparam logic [7:0] CT = WATCHDOG_RESET_CAUSE_FLAG_CTRL_ADDR;
  localparam logic [7:0] CA = WATCHDOG_RESET_CAUSE_FLAG_CAUSE_ADDR;
  logic        clk, sys_rst, avs_read, avs_write, avs_waitrequest;
  logic [7:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata;
  logic [3:0]  avs_byteenable;
  logic        slow_osc, always_on_fuse, global_int_enable, vector_ack, restart_req;
  logic        brownout_event, external_event, wdog_irq, wdog_reset_pulse, prev_pulse;
  int          failures, num_checks, rst_hi = 0, rst_rise = 0;
  watchdog_reset_cause_flag_row_t   rows [22];
  // Short base period keeps every time-out within a few slow ticks
  watchdog_reset_cause_flag_watchdog #(.BASE_TICKS(4)) uut (
    .clk(clk), .sys_rst(sys_rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .slow_osc(slow_osc),
    .always_on_fuse(always_on_fuse), .global_int_enable(global_int_enable),
    .vector_ack(vector_ack), .restart_req(restart_req), .brownout_event(brownout_event),
    .external_event(external_event), .wdog_irq(wdog_irq), .wdog_reset_pulse(wdog_reset_pulse));
  // ------------------------------------------------------------
  // Clock and reset-pulse monitor
  // ------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Counts pulses and high cycles, so a stretched pulse shows up
  always @(posedge clk) begin
    if (wdog_reset_pulse === 1'b1) rst_hi++;
    if (wdog_reset_pulse === 1'b1 && prev_pulse !== 1'b1) rst_rise++;
    prev_pulse <= wdog_reset_pulse;
  end
  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic print_verdict();
    $display("checks %0d, mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // One Avalon transfer; the edge at the start keeps release and raise apart
  task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d,
                     output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= {24'h000000, d};
    avs_write <= wr;
    avs_read <= ~wr;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    if (n >= 20) begin
      failures++;
      $display("[FAIL] %0t ns: bus wait ran out", $time);
      print_verdict();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    logic [31:0] q;
    bus(1'b0, a, 8'h00, q);
    `CHK(q, {24'h000000, e})
  endtask
  // Slow oscillator runs only when a test wants ticks
  task automatic tick(input int n);
    repeat (n) begin
      slow_osc <= 1'b1;
      repeat (4) @(posedge clk);
      slow_osc <= 1'b0;
      repeat (4) @(posedge clk);
    end
  endtask
  task automatic pulse_restart();
    restart_req <= 1'b1;
    @(posedge clk);
    restart_req <= 1'b0;
  endtask
  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    {avs_read, avs_write, slow_osc, vector_ack, restart_req} = 5'h00;
    {brownout_event, external_event} = 2'h0;
    avs_address = 8'h00;
    avs_writedata = 32'h00000000;
    avs_byteenable = 4'hF;
    always_on_fuse = 1'b1;
    global_int_enable = 1'b1;
    sys_rst = 1'b1;
    failures = 0;
    num_checks = 0;
    rows = '{
      '{0, CA, 8'h01, 0}, '{0, CT, 8'h00, 0},
      '{1, CA, 8'h00, 0}, '{0, CA, 8'h00, 0},
      '{1, CT, 8'h40, 0}, '{0, CT, 8'h40, 0},
      '{1, CT, 8'h18, 0}, '{1, CT, 8'h0D, 0}, '{0, CT, 8'h0D, 0},
      '{1, CT, 8'h00, 0}, '{0, CT, 8'h0D, 0},
      '{1, CT, 8'h18, 0}, '{1, CT, 8'h2A, 0}, '{0, CT, 8'h0D, 0},
      '{1, 8'h10, 8'hFF, 0}, '{0, 8'h10, 8'h00, 0},
      '{1, CT, 8'h18, 3}, '{1, CT, 8'h00, 0}, '{0, CT, 8'h0D, 0},
      '{1, CT, 8'h18, 0}, '{1, CT, 8'h00, 0}, '{0, CT, 8'h00, 0}
    };
    repeat (5) @(posedge clk);
    sys_rst <= 1'b0;
    pulse_restart();
    // Register table: writes, reads and the protected window
    foreach (rows[i]) begin
      if (rows[i].wr) wr(rows[i].a, rows[i].d);
      else rd(rows[i].a, rows[i].d);
      repeat (rows[i].gap) @(posedge clk);
    end
    $display("test register table done");
    // Interrupt mode; second restart must hold the count back
    wr(CT, 8'h40);
    pulse_restart();
    tick(3);
    pulse_restart();
    tick(2);
    rd(CT, 8'h40);
    `CHK(wdog_irq, 1'b0)
    tick(4);
    rd(CT, 8'hC0);
    `CHK(wdog_irq, 1'b1)
    global_int_enable <= 1'b0;
    repeat (2) @(posedge clk);
    `CHK(wdog_irq, 1'b0)
    global_int_enable <= 1'b1;
    wr(CT, 8'hC0);
    rd(CT, 8'h40);
    pulse_restart();
    tick(6);
    vector_ack <= 1'b1;
    @(posedge clk);
    vector_ack <= 1'b0;
    rd(CT, 8'h40);
    `CHK(rst_rise, 0)
    $display("test interrupt mode done");
    // Combined mode: vector drops to reset mode, missed vector resets
    wr(CT, 8'h48);
    pulse_restart();
    tick(6);
    rd(CT, 8'hC8);
    vector_ack <= 1'b1;
    @(posedge clk);
    vector_ack <= 1'b0;
    rd(CT, 8'h08);
    wr(CT, 8'h48);
    pulse_restart();
    tick(6);
    `CHK(rst_rise, 0)
    tick(5);
    `CHK(rst_rise, 1)
    `CHK(rst_hi, 1)
    rd(CA, 8'h08);
    wr(CT, 8'h18);
    wr(CT, 8'h00);
    rd(CT, 8'h08);
    wr(CA, 8'h00);
    rd(CT, 8'h08);
    wr(CT, 8'h18);
    wr(CT, 8'h00);
    rd(CT, 8'h00);
    $display("test combined mode done");
    // Other reset causes; writing one leaves a flag alone
    brownout_event <= 1'b1;
    external_event <= 1'b1;
    @(posedge clk);
    brownout_event <= 1'b0;
    external_event <= 1'b0;
    rd(CA, 8'h06);
    wr(CA, 8'h04);
    rd(CA, 8'h04);
    wr(CA, 8'hF0);
    rd(CA, 8'h00);
    $display("test reset causes done");
    // Programmed fuse forces reset mode whatever the enables say
    always_on_fuse <= 1'b0;
    repeat (4) @(posedge clk);
    wr(CT, 8'h40);
    rd(CT, 8'h08);
    pulse_restart();
    tick(6);
    `CHK(rst_rise, 2)
    `CHK(rst_hi, 2)
    rd(CA, 8'h08);
    $display("test fuse done");
    // Mid-run reset acts as power-on: only the power-on cause remains
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    rd(CA, 8'h01);
    rd(CT, 8'h08);
    `CHK(wdog_reset_pulse, 1'b0)
    $display("test second reset done");
    print_verdict();
  end
endmodule
`undef CHK
`default_nettype wire
